//--- rtl/fault_handler_control_status.sv
// Handler control/state register and combined fault status register of the core.
// Assumes fault events and pending/active updates come from core logic on i_clk,
// and register requests on a simple valid/write port synchronous to i_clk.
//
// Notes on behaviour
// RULE1: Enable bits 18..16 for usage, bus, protection faults; write 1 enables.
// RULE2: Pending bits read 1 while pending; software writes change pending status.
// RULE3: Active bits read 1 while active; software writes change active status.
// RULE4: A fault whose handler is disabled is raised as hard fault instead.
// RULE5: Software altering active bits keeps stacked context and restores state.
// RULE6: After enabling, software changes single bits by read-modify-write only.
// RULE7: Status word: protection byte 7..0, bus byte 15..8, usage 31..16.
// RULE8: Access size decode: word, halfword, byte at base, base+1, base+2; a halfword at base+1 is refused as misaligned.
// RULE9: Status bit 7 shows whether the protection fault address is valid.
// RULE10: Hard fault handler clears address-valid after priority escalation.
// RULE11: Stacking violation sets its flag and loads no protection address.
// RULE12: Unstacking violation sets its flag and loads no fault address.
// RULE13: Data access violation sets flag and loads protection fault address.
// RULE14: Fetch violation sets its flag and loads no fault address.
// RULE15: Bus address-valid set on known-address bus fault; later faults clear; here only a protection data violation, later or in the same cycle, clears it.
// RULE16: Bus stacking error sets its flag and writes no bus address.
// RULE17: Bus unstacking error sets its flag and writes no bus address.
// RULE18: Imprecise bus error sets flag, no address; fault stays pending.
// RULE19: Imprecise and precise flags may stand set together.
// RULE20: Precise bus error sets bit 1 and loads the bus fault address; here a data violation in the same cycle keeps that address out.
// RULE21: Instruction bus error sets bit 0 on issue, no address recorded.
// RULE22: Status flags are sticky until written with 1 or reset.
// RULE23: Reserved bits read zero and ignore writes.
`timescale 1ns/1ps
`include "fault_status_regs.svh"

module fault_handler_control_status
    import fault_status_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire bus_req_t i_bus,
    input wire fault_event_t i_event,
    input wire exc_update_t i_exc,
    output logic [31:0] o_rdata,
    output logic o_ack,
    output logic o_err,
    output logic o_hard_fault,
    output handler_view_t o_view
);

    // ----------------------------------------------------------------
    // Functions
    // ----------------------------------------------------------------

    // Byte lanes covered by an access
    function automatic logic [31:0] lane_mask(input logic [1:0] off, input access_size_t sz);
        logic [31:0] m;
        m = 32'hFFFFFFFF;
        case (sz)
            SIZE_BYTE: m = 32'h000000FF << {off, 3'b000};
            SIZE_HALF: m = off[1] ? 32'hFFFF0000 : 32'h0000FFFF;
            default: m = 32'hFFFFFFFF;
        endcase
        return m;
    endfunction : lane_mask

    // Spread the seven active bits onto their register positions
    function automatic logic [31:0] act_spread(input logic [6:0] a);
        logic [31:0] w;
        w = 32'h00000000;
        w[11] = a[6];
        w[10] = a[5];
        w[8] = a[4];
        w[7] = a[3];
        w[3] = a[2];
        w[1] = a[1];
        w[0] = a[0];
        return w;
    endfunction : act_spread

    // Gather the seven active bits from their register positions
    function automatic logic [6:0] act_gather(input logic [31:0] w);
        return {w[11], w[10], w[8], w[7], w[3], w[1], w[0]};
    endfunction : act_gather

    // Register selected by an address and size
    function automatic reg_sel_t decode(input logic [31:0] a, input access_size_t sz);
        reg_sel_t r;
        logic [31:0] word;
        word = {a[31:2], 2'b00};
        r = SEL_NONE;
        if (word == `HCS_ADDR) begin
            r = SEL_CTRL;
        end else if (word == `CFS_ADDR) begin
            r = SEL_STATUS;
        end else if (word == `PFA_ADDR && sz == SIZE_WORD) begin
            r = SEL_PADDR;
        end else if (word == `BFA_ADDR && sz == SIZE_WORD) begin
            r = SEL_BADDR;
        end
        // Misaligned halfword or word is not mapped
        if (sz == SIZE_HALF && a[0]) begin
            r = SEL_NONE;
        end
        if (sz == SIZE_WORD && a[1:0] != 2'b00) begin
            r = SEL_NONE;
        end
        return r;
    endfunction : decode

    // ----------------------------------------------------------------
    // Reset release
    // ----------------------------------------------------------------

    logic [1:0] rst_sync_reg;
    logic rstn;

    // Two-stage release of the asynchronous reset
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rst_sync_reg <= 2'b00;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end

    assign rstn = rst_sync_reg[1];

    // ----------------------------------------------------------------
    // Request decode
    // ----------------------------------------------------------------

    state_t s_reg;
    state_t s_next;
    logic take;
    reg_sel_t req_sel;
    logic [31:0] req_mask;
    logic sw_wr;
    logic [31:0] mem_q;
    logic mem_we;
    logic mem_waddr;
    logic [31:0] mem_wdata;
    logic mem_raddr;

    // Accept one request whenever no earlier one is in flight
    assign take = i_bus.valid && !s_reg.busy;
    assign req_sel = decode(i_bus.addr, i_bus.size); // RULE8
    assign req_mask = lane_mask(i_bus.addr[1:0], i_bus.size); // RULE8
    assign sw_wr = take && i_bus.write;

    // ----------------------------------------------------------------
    // Fault classification
    // ----------------------------------------------------------------

    logic mem_any;
    logic bus_any;
    logic usage_any;
    logic [2:0] ena;
    logic bus_addr_load;

    // Group the events by the exception that handles them
    assign mem_any = i_event.mem_stack | i_event.mem_unstack
                   | i_event.mem_data | i_event.mem_fetch;
    assign bus_any = i_event.bus_stack | i_event.bus_unstack | i_event.bus_imprecise
                   | i_event.bus_precise | i_event.bus_instr;
    assign usage_any = |i_event.usage_flags;
    assign ena = s_reg.ctrl[`HCS_ENA_LSB +: `HCS_ENA_W];

    // The store has one write port; a protection address takes it first
    assign bus_addr_load = i_event.bus_precise && !i_event.mem_data;

    // ----------------------------------------------------------------
    // Fault address store
    // ----------------------------------------------------------------

    // Core loads addresses; software may write whole words when the core is idle
    always_comb begin
        mem_we = 1'b0;
        mem_waddr = `SLOT_PROT;
        mem_wdata = i_event.addr;
        if (i_event.mem_data) begin
            mem_we = 1'b1; // RULE13
            mem_waddr = `SLOT_PROT;
        end else if (i_event.bus_precise) begin
            mem_we = 1'b1; // RULE20
            mem_waddr = `SLOT_BUS;
        end else if (sw_wr && (req_sel == SEL_PADDR || req_sel == SEL_BADDR)) begin
            mem_we = 1'b1;
            mem_waddr = (req_sel == SEL_BADDR) ? `SLOT_BUS : `SLOT_PROT;
            mem_wdata = i_bus.wdata;
        end
    end

    assign mem_raddr = (req_sel == SEL_BADDR) ? `SLOT_BUS : `SLOT_PROT;

    fault_addr_mem #(
        .WIDTH(32),
        .DEPTH(2),
        .AW(1)
    ) u_addr_mem (
        .i_clk(i_clk),
        .i_rstn(rstn),
        .i_we(mem_we),
        .i_waddr(mem_waddr),
        .i_wdata(mem_wdata),
        .i_raddr(mem_raddr),
        .o_rdata(mem_q)
    );

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------

    logic [31:0] ctrl_v;
    logic [31:0] stat_set;
    logic [31:0] stat_clr;
    logic [3:0] pend_v;
    logic [6:0] act_v;
    logic [3:0] fault_pend;

    // Control register, status flags and the answer pipeline
    always_comb begin
        s_next = s_reg;
        s_next.ack = 1'b0;
        s_next.err = 1'b0;
        s_next.hard_fault = 1'b0;
        stat_set = 32'h00000000;
        stat_clr = 32'h00000000;
        fault_pend = 4'h0;

        // Software write merged into the byte lanes it covers
        ctrl_v = s_reg.ctrl;
        if (sw_wr && req_sel == SEL_CTRL) begin
            ctrl_v = (s_reg.ctrl & ~req_mask) | (i_bus.wdata & req_mask); // RULE1 RULE2 RULE3
        end

        // Enabled faults become pending, disabled ones go to hard fault
        if (mem_any) begin
            if (ena[0]) begin
                fault_pend[1] = 1'b1;
            end else begin
                s_next.hard_fault = 1'b1; // RULE4
            end
        end
        if (bus_any) begin
            if (ena[1]) begin
                fault_pend[2] = 1'b1; // RULE18
            end else begin
                s_next.hard_fault = 1'b1; // RULE4
            end
        end
        if (usage_any) begin
            if (ena[2]) begin
                fault_pend[0] = 1'b1;
            end else begin
                s_next.hard_fault = 1'b1; // RULE4
            end
        end

        // Core updates apply after software; a set beats any clear
        pend_v = ctrl_v[`HCS_PEND_LSB +: `HCS_PEND_W];
        pend_v = (pend_v & ~i_exc.pend_clr) | i_exc.pend_set | fault_pend; // RULE2
        act_v = act_gather(ctrl_v);
        act_v = (act_v & ~i_exc.act_clr) | i_exc.act_set; // RULE3
        ctrl_v[`HCS_PEND_LSB +: `HCS_PEND_W] = pend_v;
        ctrl_v = (ctrl_v & ~act_spread(7'h7F)) | act_spread(act_v);
        s_next.ctrl = ctrl_v & `HCS_MASK; // RULE23

        // Protection fault flags; only data violations give an address
        stat_set[`MPF_LSB + `BIT_STACK] = i_event.mem_stack; // RULE11
        stat_set[`MPF_LSB + `BIT_UNSTACK] = i_event.mem_unstack; // RULE12
        stat_set[`MPF_LSB + `BIT_DATA] = i_event.mem_data; // RULE13
        stat_set[`MPF_LSB + `BIT_FETCH] = i_event.mem_fetch; // RULE14
        stat_set[`MPF_LSB + `BIT_ADDR_VALID] = i_event.mem_data; // RULE9

        // Bus fault flags; only precise errors give an address
        stat_set[`BSF_LSB + `BIT_STACK] = i_event.bus_stack; // RULE16
        stat_set[`BSF_LSB + `BIT_UNSTACK] = i_event.bus_unstack; // RULE17
        stat_set[`BSF_LSB + `BIT_IMPRECISE] = i_event.bus_imprecise; // RULE18
        stat_set[`BSF_LSB + `BIT_DATA] = i_event.bus_precise; // RULE20
        stat_set[`BSF_LSB + `BIT_FETCH] = i_event.bus_instr; // RULE21
        stat_set[`BSF_LSB + `BIT_ADDR_VALID] = bus_addr_load; // RULE15

        // Usage fault flags in the upper halfword
        stat_set[`USF_LSB +: 16] = i_event.usage_flags; // RULE7

        // A later protection fault with an address voids the bus address
        if (i_event.mem_data && !bus_addr_load) begin
            stat_clr[`BSF_LSB + `BIT_ADDR_VALID] = 1'b1; // RULE15
        end

        // Software write of one clears the flags in its lanes
        if (sw_wr && req_sel == SEL_STATUS) begin
            stat_clr = stat_clr | (i_bus.wdata & req_mask); // RULE22
        end

        // Sticky flags: set wins over clear, independent flags coexist
        s_next.status = ((s_reg.status & ~stat_clr) | stat_set) & `CFS_MASK; // RULE19 RULE22

        // Answer pipeline: capture the request, then return data
        if (take) begin
            s_next.busy = 1'b1;
            s_next.sel = req_sel;
            s_next.mask = req_mask;
        end else if (s_reg.busy) begin
            s_next.busy = 1'b0;
            s_next.ack = 1'b1;
            s_next.err = (s_reg.sel == SEL_NONE);
            case (s_reg.sel)
                SEL_CTRL: s_next.rdata = s_reg.ctrl & s_reg.mask; // RULE23
                SEL_STATUS: s_next.rdata = s_reg.status & s_reg.mask; // RULE7 RULE8
                SEL_PADDR: s_next.rdata = mem_q;
                SEL_BADDR: s_next.rdata = mem_q;
                default: s_next.rdata = 32'h00000000;
            endcase
        end

        // Handler view for the exception logic
        s_next.view.enable = s_next.ctrl[`HCS_ENA_LSB +: `HCS_ENA_W]; // RULE1
        s_next.view.pending = s_next.ctrl[`HCS_PEND_LSB +: `HCS_PEND_W];
        s_next.view.active = act_gather(s_next.ctrl);
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------

    // All state but the reset release and the address store in one register
    always_ff @(posedge i_clk or negedge rstn) begin
        if (!rstn) begin
            s_reg <= '0;
            s_reg.ctrl <= `HCS_RESET;
            s_reg.status <= `CFS_RESET;
            s_reg.sel <= SEL_NONE;
        end else begin
            s_reg <= s_next;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------

    // Every output is a field of the state register
    assign o_rdata = s_reg.rdata;
    assign o_ack = s_reg.ack;
    assign o_err = s_reg.err;
    assign o_hard_fault = s_reg.hard_fault;
    assign o_view = s_reg.view;

endmodule : fault_handler_control_status

//--- rtl/fault_status_regs.svh
// Addresses, field positions, masks and reset values of the fault control and status block.
// Assumes a 32-bit byte-addressed register port; addresses are byte addresses.
`ifndef FAULT_STATUS_REGS_SVH
`define FAULT_STATUS_REGS_SVH

// ----------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------
`define HCS_ADDR 32'hE000ED24
`define CFS_ADDR 32'hE000ED28
`define BFS_ADDR 32'hE000ED29
`define UFS_ADDR 32'hE000ED2A
`define PFA_ADDR 32'hE000ED34
`define BFA_ADDR 32'hE000ED38

// ----------------------------------------------------------------
// Handler control and state fields
// ----------------------------------------------------------------
`define HCS_ENA_LSB 16
`define HCS_PEND_LSB 12
`define HCS_ENA_W 3
`define HCS_PEND_W 4
`define HCS_ACT_W 7
`define HCS_MASK 32'h0007FD8B
`define HCS_RESET 32'h00000000

// ----------------------------------------------------------------
// Combined fault status fields
// ----------------------------------------------------------------
`define MPF_LSB 0
`define BSF_LSB 8
`define USF_LSB 16
`define BIT_ADDR_VALID 7
`define BIT_STACK 4
`define BIT_UNSTACK 3
`define BIT_IMPRECISE 2
`define BIT_DATA 1
`define BIT_FETCH 0
`define CFS_MASK 32'h030F9F9B
`define CFS_RESET 32'h00000000

// ----------------------------------------------------------------
// Address store slots
// ----------------------------------------------------------------
`define SLOT_PROT 1'b0
`define SLOT_BUS 1'b1

`endif

//--- rtl/fault_status_pkg.sv
// Types shared by the fault control and status block, its monitor and its bench.
// Assumes fault_status_regs.svh supplies the numeric constants.
package fault_status_pkg;

    // Size of a register port access
    typedef enum logic [1:0] {SIZE_BYTE, SIZE_HALF, SIZE_WORD} access_size_t;

    // Register selected by an access
    typedef enum logic [2:0] {SEL_NONE, SEL_CTRL, SEL_STATUS, SEL_PADDR, SEL_BADDR} reg_sel_t;

    // Register port request
    typedef struct packed {
        logic valid;
        logic write;
        access_size_t size;
        logic [31:0] addr;
        logic [31:0] wdata;
    } bus_req_t;

    // Fault events reported by the core, one cycle each
    typedef struct packed {
        logic mem_stack;
        logic mem_unstack;
        logic mem_data;
        logic mem_fetch;
        logic bus_stack;
        logic bus_unstack;
        logic bus_imprecise;
        logic bus_precise;
        logic bus_instr;
        logic [15:0] usage_flags;
        logic [31:0] addr;
    } fault_event_t;

    // Pending and active updates from the exception logic
    typedef struct packed {
        logic [3:0] pend_set;
        logic [3:0] pend_clr;
        logic [6:0] act_set;
        logic [6:0] act_clr;
    } exc_update_t;

    // Handler view seen by the exception logic
    typedef struct packed {
        logic [2:0] enable;
        logic [3:0] pending;
        logic [6:0] active;
    } handler_view_t;

    // State of the top module apart from the reset release and the address store
    typedef struct packed {
        logic [31:0] ctrl;
        logic [31:0] status;
        logic busy;
        reg_sel_t sel;
        logic [31:0] mask;
        logic [31:0] rdata;
        logic ack;
        logic err;
        logic hard_fault;
        handler_view_t view;
    } state_t;

endpackage : fault_status_pkg

//--- rtl/fault_addr_mem.sv
// Small store for the two fault address words.
// Assumes one write per cycle and an asynchronous active-low reset.
`timescale 1ns/1ps

module fault_addr_mem #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 2,
    parameter int AW = 1
) (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_we,
    input wire logic [AW-1:0] i_waddr,
    input wire logic [WIDTH-1:0] i_wdata,
    input wire logic [AW-1:0] i_raddr,
    output logic [WIDTH-1:0] o_rdata
);

    logic [WIDTH-1:0] mem_reg [DEPTH];

    // Storage write
    always_ff @(posedge i_clk) begin
        if (i_we) begin
            mem_reg[i_waddr] <= i_wdata;
        end
    end

    // Registered read
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_rdata <= '0;
        end else begin
            o_rdata <= mem_reg[i_raddr];
        end
    end

endmodule : fault_addr_mem

//--- tb/fault_handler_control_status_monitor.sv
// Concurrent checks on the ports of the fault control and status block.
// Assumes requests follow the two-cycle register port handshake on i_clk.
`timescale 1ns/1ps
`include "fault_status_regs.svh"

module fault_handler_control_status_monitor
    import fault_status_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire bus_req_t i_bus,
    input wire fault_event_t i_event,
    input wire exc_update_t i_exc,
    input wire logic [31:0] o_rdata,
    input wire logic o_ack,
    input wire logic o_err,
    input wire logic o_hard_fault,
    input wire handler_view_t o_view
);
    // ----------------------------------------
    // Helper logic
    // ----------------------------------------
    logic busy_reg;
    logic take;
    logic ctrl_wr;
    logic [2:0] kind;

    // Request acceptance and fault groups in enable bit order
    assign take = i_bus.valid && !busy_reg;
    assign ctrl_wr = take && i_bus.write && (i_bus.addr == `HCS_ADDR);
    assign kind[0] = i_event.mem_stack | i_event.mem_unstack | i_event.mem_data
        | i_event.mem_fetch;
    assign kind[1] = i_event.bus_stack | i_event.bus_unstack | i_event.bus_imprecise
        | i_event.bus_precise | i_event.bus_instr;
    assign kind[2] = |(i_event.usage_flags & 16'h030F);

    // Port is busy for one cycle after a take
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            busy_reg <= 1'b0;
        end else begin
            busy_reg <= take;
        end
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    a_ack_latency: assert property (take |-> ##2 o_ack)
        else $error("no answer two cycles after a request");
    a_ack_cause: assert property (o_ack |-> $past(take, 2))
        else $error("answer without a request");
    a_err_data: assert property (o_err |-> o_ack && o_rdata == 32'h0)
        else $error("refused access returned data");
    a_hard_disabled: assert property ((|(kind & ~o_view.enable)) && !ctrl_wr
        |=> o_hard_fault)
        else $error("disabled fault not raised as hard fault");
    a_hard_cause: assert property (o_hard_fault |-> $past(|kind))
        else $error("hard fault without a fault");
    a_bus_pending: assert property (kind[1] && o_view.enable[1] && !ctrl_wr
        |=> o_view.pending[2])
        else $error("enabled bus fault not pending");
    a_active_set: assert property (|i_exc.act_set |=>
        (o_view.active & $past(i_exc.act_set)) == $past(i_exc.act_set))
        else $error("active set not shown");
    a_enable_hold: assert property (!ctrl_wr |=> o_view.enable == $past(o_view.enable))
        else $error("enable changed without a write");

    c_hard: cover property (o_hard_fault);
    c_err: cover property (o_err);
    c_ctrl_wr: cover property (ctrl_wr);
endmodule : fault_handler_control_status_monitor

bind fault_handler_control_status fault_handler_control_status_monitor u_monitor (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_bus(i_bus), .i_event(i_event), .i_exc(i_exc),
    .o_rdata(o_rdata), .o_ack(o_ack), .o_err(o_err), .o_hard_fault(o_hard_fault), .o_view(o_view)
);

//--- tb/core_fault_model.sv
// Behavioural stand-in for the core's exception and memory access logic.
// Assumes one bench process calls its tasks; outputs change after i_clk edges.
`timescale 1ns/1ps

module core_fault_model
    import fault_status_pkg::*;
(
    input wire logic i_clk,
    output fault_event_t o_event,
    output exc_update_t o_exc
);
    // Quiet at time zero
    initial begin
        o_event = '0;
        o_exc = '0;
    end

    // One-cycle fault report; the address line is scrambled afterwards
    task automatic fault(input fault_event_t e);
        @(posedge i_clk);
        o_event <= e;
        @(posedge i_clk);
        o_event <= {25'h0, ~e.addr};
    endtask : fault

    // One-cycle pending or active update
    task automatic update(input exc_update_t u);
        @(posedge i_clk);
        o_exc <= u;
        @(posedge i_clk);
        o_exc <= '0;
    endtask : update
endmodule : core_fault_model

//--- tb/fault_handler_control_status_tb.sv
// Self-checking bench for the fault control and status block.
// Assumes the core model drives fault events and the bench the register port.
`timescale 1ns/1ps
`include "fault_status_regs.svh"

module fault_handler_control_status_tb
    import fault_status_pkg::*;
    ;
    logic i_clk;
    logic i_rstn;
    bus_req_t i_bus;
    fault_event_t i_event;
    exc_update_t i_exc;
    logic [31:0] o_rdata;
    logic o_ack, o_err, o_hard_fault;
    handler_view_t o_view;
    int errors, n_compared, cycles;
    logic [31:0] q, exp_st;
    logic e;
    int order[10] = '{22, 21, 23, 24, 17, 18, 19, 20, 16, 22};
    int sb[9] = '{8, 9, 10, 11, 12, 0, 1, 3, 4};
    logic [31:0] la[4] = '{`CFS_ADDR, `CFS_ADDR, `BFS_ADDR, `UFS_ADDR};
    access_size_t ls[4] = '{SIZE_BYTE, SIZE_HALF, SIZE_BYTE, SIZE_HALF};
    logic [31:0] lm[4] = '{32'h000000FF, 32'h0000FFFF, 32'h0000FF00, 32'hFFFF0000};

    fault_handler_control_status u_fault_handler_control_status (
        .i_clk(i_clk), .i_rstn(i_rstn), .i_bus(i_bus), .i_event(i_event), .i_exc(i_exc),
        .o_rdata(o_rdata), .o_ack(o_ack), .o_err(o_err), .o_hard_fault(o_hard_fault),
        .o_view(o_view)
    );
    core_fault_model u_core_fault_model (.i_clk(i_clk), .o_event(i_event), .o_exc(i_exc));

    // ----------------------------------------
    // Clock, timeout and helpers
    // ----------------------------------------
    initial begin
        i_clk = 1'b0;
        forever #20 i_clk = ~i_clk;
    end

    // Cut a hang short
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 3000) begin
            errors++;
            $display("MISMATCH at %0t: run did not finish", $time);
            wrap_up();
        end
    end

    task automatic wrap_up;
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : wrap_up

    task automatic chk(input logic [31:0] seen, input logic [31:0] want, input string what);
        n_compared++;
        if (seen !== want) begin
            errors++;
            $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, want);
        end
    endtask : chk

    // One register access; request dropped after the taking edge, answer two edges on
    task automatic access(input logic w, input access_size_t sz, input logic [31:0] a,
            input logic [31:0] d, output logic [31:0] rd, output logic er);
        @(posedge i_clk);
        i_bus <= '{valid: 1'b1, write: w, size: sz, addr: a, wdata: d};
        @(posedge i_clk);
        i_bus <= '{valid: 1'b0, write: w, size: sz, addr: ~a, wdata: ~d};
        @(posedge i_clk);
        #1;
        chk({31'h0, o_ack}, 32'h1, "answer");
        rd = o_rdata;
        er = o_err;
    endtask : access

    task automatic wr(input logic [31:0] a, input access_size_t sz, input logic [31:0] d);
        access(1'b1, sz, a, d, q, e);
    endtask : wr

    task automatic rdc(input logic [31:0] a, input access_size_t sz, input logic [31:0] want,
            input string what);
        access(1'b0, sz, a, 32'h0, q, e);
        chk(q, want, what);
    endtask : rdc
    function automatic fault_event_t ev(input int i, input logic [31:0] a);
        ev = fault_event_t'({(25'h1 << i), a});
    endfunction : ev

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        i_rstn = 1'b0;
        i_bus = '0;
        errors = 0;
        n_compared = 0;
        cycles = 0;
        repeat (2) @(posedge i_clk);
        i_rstn <= 1'b1;
        repeat (3) @(posedge i_clk);
        rdc(`HCS_ADDR, SIZE_WORD, `HCS_RESET, "control reset");
        rdc(`CFS_ADDR, SIZE_WORD, `CFS_RESET, "status reset");
        wr(`HCS_ADDR, SIZE_WORD, 32'hFFFFFFFF);
        rdc(`HCS_ADDR, SIZE_WORD, `HCS_MASK, "control fields");
        chk({29'h0, o_view.enable}, 32'h7, "view enable");
        wr(`HCS_ADDR, SIZE_WORD, 32'h0);
        rdc(`HCS_ADDR, SIZE_WORD, 32'h0, "control cleared");
        $display("test control done");
        // Fault with its handler disabled
        u_core_fault_model.fault(ev(22, 32'hA0000000));
        #1;
        chk({31'h0, o_hard_fault}, 32'h1, "hard fault");
        chk({28'h0, o_view.pending}, 32'h0, "no pending");
        rdc(`CFS_ADDR, SIZE_WORD, 32'h00000082, "data violation");
        wr(`CFS_ADDR, SIZE_WORD, 32'hFFFFFFFF);
        rdc(`CFS_ADDR, SIZE_WORD, 32'h0, "all cleared");
        $display("test disabled fault done");
        // Enable by read-modify-write, then every fault kind
        access(1'b0, SIZE_WORD, `HCS_ADDR, 32'h0, q, e);
        wr(`HCS_ADDR, SIZE_WORD, q | 32'h00070000);
        exp_st = 32'h0;
        foreach (order[k]) begin
            u_core_fault_model.fault(ev(order[k], {28'hA000000, k[3:0]}));
            exp_st |= 32'h1 << sb[order[k] - 16];
            if (order[k] == 22) exp_st = (exp_st | 32'h80) & ~32'h8000;
            if (order[k] == 17) exp_st |= 32'h8000;
            rdc(`CFS_ADDR, SIZE_WORD, exp_st, "event flags");
        end
        rdc(`PFA_ADDR, SIZE_WORD, 32'hA0000009, "protection address");
        rdc(`BFA_ADDR, SIZE_WORD, 32'hA0000004, "bus address");
        u_core_fault_model.fault(fault_event_t'({25'h0FFFF, 32'h0}));
        #1;
        chk({28'h0, o_view.pending}, 32'h7, "pending faults");
        exp_st |= 32'h030F0000;
        rdc(`CFS_ADDR, SIZE_WORD, exp_st, "status word");
        for (int j = 0; j < 4; j++) rdc(la[j], ls[j], exp_st & lm[j], "lane view");
        $display("test fault flags done");
        // Write one to clear, lane by lane
        wr(`BFS_ADDR, SIZE_BYTE, 32'h0000FF00);
        exp_st &= ~32'h0000FF00;
        rdc(`CFS_ADDR, SIZE_WORD, exp_st, "bus byte cleared");
        wr(`UFS_ADDR, SIZE_HALF, 32'hFFFFFFFF);
        rdc(`CFS_ADDR, SIZE_WORD, exp_st & 32'h0000FFFF, "usage cleared");
        access(1'b0, SIZE_WORD, 32'hE000ED30, 32'h0, q, e);
        chk({31'h0, e}, 32'h1, "unmapped refused");
        chk(q, 32'h0, "unmapped data");
        access(1'b0, SIZE_HALF, `BFS_ADDR, 32'h0, q, e);
        chk({31'h0, e}, 32'h1, "misaligned refused");
        $display("test clear and decode done");
        // Pending by software, active by core, then restore saved state
        rdc(`HCS_ADDR, SIZE_WORD, 32'h00077000, "saved control");
        wr(`HCS_ADDR, SIZE_WORD, 32'h00078000);
        rdc(`HCS_ADDR, SIZE_WORD, 32'h00078000, "pending write");
        u_core_fault_model.update('{act_set: 7'h7F, default: '0});
        #1;
        chk({25'h0, o_view.active}, 32'h7F, "active view");
        rdc(`HCS_ADDR, SIZE_WORD, 32'h00078D8B, "active read");
        wr(`HCS_ADDR, SIZE_WORD, 32'h00077000);
        rdc(`HCS_ADDR, SIZE_WORD, 32'h00077000, "restored");
        $display("test pending and active done");
        wrap_up();
    end
endmodule : fault_handler_control_status_tb
